// file: include/sfr_cfg.svh
/*
 * Opcodes, field positions, reset values, latency tables and edge counts
 * for the serial array read block.
 * Assumes it is included by bare name and that every user also imports sfr_pkg.
 */
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

// read opcodes, 3-byte (or wide) and always-4-byte forms
`define SFR_OP_READ3 8'h03
`define SFR_OP_READ4 8'h13
`define SFR_OP_FAST3 8'h0B
`define SFR_OP_FAST4 8'h0C
`define SFR_OP_QOUT3 8'h6B
`define SFR_OP_QOUT4 8'h6C
`define SFR_OP_QIO3 8'hEB
`define SFR_OP_QIO4 8'hEC
`define SFR_OP_QDDR3 8'hED
`define SFR_OP_QDDR4 8'hEE

// edges per phase
`define SFR_OPCODE_EDGES 6'h08
`define SFR_ADDR_EDGES_S3 6'h18
`define SFR_ADDR_EDGES_S4 6'h20
`define SFR_ADDR_EDGES_Q3 6'h06
`define SFR_ADDR_EDGES_Q4 6'h08
`define SFR_MODE_EDGES 6'h02

// config register one and bank register fields
`define SFR_CR1_QUAD_BIT 1
`define SFR_CR1_LC_LSB 6
`define SFR_BANK_WIDE_BIT 7
`define SFR_BANK_RESET 8'h00
`define SFR_XIP_NIBBLE 4'hA

// dummy cycles per latency code, one nibble per code, code 0 lowest
`define SFR_DUMMY_FAST 16'h0888
`define SFR_DUMMY_QOUT 16'h0458
`define SFR_DUMMY_QIO 16'h1454
`define SFR_DUMMY_QDDR 16'h7656

// learning pattern window and lane enables
`define SFR_DLP_START 4'h4
`define SFR_DLP_FIRST 3'h7
`define SFR_OE_NONE 8'h00
`define SFR_OE_SINGLE 8'h22
`define SFR_OE_QUAD 8'hFF

// sizes
`define SFR_FIFO_DEPTH 32
`define SFR_BYTE_W 8
`define SFR_ADDR_W 32
`define SFR_PIN_W 10
`define SFR_PIN_IDLE 10'h200

`endif

// file: include/sfr_pkg.sv
/*
 * Types shared by the serial array read block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfr_pkg;

    // command phase as seen from the serial clock edges
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_OPC = 3'b001,
        ST_ADDR = 3'b010,
        ST_MODE = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA = 3'b101,
        ST_IGNORE = 3'b110
    } sfr_state_t;

    // read command family
    typedef enum logic [2:0]
    {
        CL_NONE = 3'b000,
        CL_READ = 3'b001,
        CL_FAST = 3'b010,
        CL_QOUT = 3'b011,
        CL_QIO = 3'b100,
        CL_QDDR = 3'b101
    } sfr_cls_t;

endpackage : sfr_pkg

// file: design/sfr_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter and edge pulses.
 * Assumes pins are asynchronous to clock; INIT is the idle level at reset.
 */
`timescale 1ns/1ps

module sfr_pin_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt, rise_r, fall_r;

    // a change counts only once stages two and three agree
    always_comb
    begin
        lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            lvl_r <= INIT;
            rise_r <= '0;
            fall_r <= '0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
            rise_r <= lvl_nxt & ~lvl_r;
            fall_r <= ~lvl_nxt & lvl_r;
        end
    end

    assign level = lvl_r;
    assign rise = rise_r;
    assign fall = fall_r;

endmodule : sfr_pin_sync

// file: design/sfr_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides and a synchronous clear.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/1ps

module sfr_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != FULL);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready && !clear;
    assign pop = out_valid && out_ready && !clear;

    // clear wins over both sides so a restart never sees stale bytes
    always_comb
    begin
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        if (clear)
        begin
            wr_nxt = '0;
            rd_nxt = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

endmodule : sfr_fifo

// file: design/sfr_array_read.sv
/*
 * Read-path command interpreter of a dual-die quad serial flash: opcode,
 * address, mode bits, latency, learning pattern and streaming data return.
 * Assumes the host drives chip select and serial clock (both sampled here),
 * and an array port that answers a byte in the cycle array_rd is high.
 */
`timescale 1ns/1ps
`include "sfr_cfg.svh"

module sfr_array_read
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cs_n_pin,
    input wire logic serial_clock_pin,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic [7:0] io_oe,
    input wire logic [7:0] config_register_one,
    input wire logic learning_pattern_on,
    input wire logic [7:0] learning_pattern,
    input wire logic bank_load,
    input wire logic [7:0] bank_load_value,
    output logic [7:0] bank_value,
    output logic [31:0] array_addr,
    output logic array_rd,
    input wire logic array_valid,
    input wire logic [7:0] array_rdata,
    output logic [31:0] read_addr,
    output logic enhanced_mode,
    output logic read_active
);
    import sfr_pkg::*;

    sfr_state_t state_r, state_nxt;
    sfr_cls_t cls_r, cls_nxt, op_cls;
    logic wide_r, wide_nxt, xip_r, xip_nxt, fetch_r, fetch_nxt;
    logic dlp_act_r, dlp_act_nxt;
    logic [5:0] cnt_r, cnt_nxt, first_cnt;
    logic [31:0] sh_r, sh_nxt, sh_shift, lat_src, lat_addr;
    logic [31:0] rd_addr_r, rd_addr_nxt, fetch_addr_r, fetch_addr_nxt;
    logic [7:0] mode_r, mode_nxt, byte_r, byte_nxt, cur, op_full;
    logic [7:0] io_out_r, io_out_nxt, io_oe_r, io_oe_nxt, bank_r, bank_nxt;
    logic [3:0] dcnt_r, dcnt_nxt, ndum;
    logic [2:0] dlp_idx_r, dlp_idx_nxt;
    logic [1:0] bit_r, bit_nxt, idx;
    logic ddr, quad_addr, cap_edge, out_edge, launch, start_lat;
    logic fifo_clear, fifo_pop, fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data, io_s;
    logic [9:0] pin_lvl, pin_rise, pin_fall;
    logic cs_rise_e, cs_fall_e, sck_rise_e, sck_fall_e, wide_address_enable;

    function automatic sfr_cls_t op_decode(input logic [7:0] op);
        sfr_cls_t c;
        case (op)
            `SFR_OP_READ3, `SFR_OP_READ4: c = CL_READ;
            `SFR_OP_FAST3, `SFR_OP_FAST4: c = CL_FAST;
            `SFR_OP_QOUT3, `SFR_OP_QOUT4: c = CL_QOUT;
            `SFR_OP_QIO3, `SFR_OP_QIO4: c = CL_QIO;
            `SFR_OP_QDDR3, `SFR_OP_QDDR4: c = CL_QDDR;
            default: c = CL_NONE;
        endcase
        return c;
    endfunction : op_decode

    // opcodes that always carry four address bytes
    function automatic logic op_is_wide(input logic [7:0] op);
        return (op == `SFR_OP_READ4) || (op == `SFR_OP_FAST4) || (op == `SFR_OP_QOUT4)
            || (op == `SFR_OP_QIO4) || (op == `SFR_OP_QDDR4);
    endfunction : op_is_wide

    function automatic logic [5:0] addr_edges(input sfr_cls_t c, input logic wide);
        if (c == CL_QIO || c == CL_QDDR)
            return wide ? `SFR_ADDR_EDGES_Q4 : `SFR_ADDR_EDGES_Q3;
        return wide ? `SFR_ADDR_EDGES_S4 : `SFR_ADDR_EDGES_S3;
    endfunction : addr_edges

    function automatic logic [3:0] dummy_count(input sfr_cls_t c, input logic [1:0] lc);
        logic [15:0] tbl;
        unique case (c)
            CL_FAST: tbl = `SFR_DUMMY_FAST;
            CL_QOUT: tbl = `SFR_DUMMY_QOUT;
            CL_QIO: tbl = `SFR_DUMMY_QIO;
            CL_QDDR: tbl = `SFR_DUMMY_QDDR;
            default: tbl = 16'h0000; // plain read has no latency
        endcase
        return tbl[{lc, 2'b00} +: 4];
    endfunction : dummy_count

    // select, clock and lanes share one chain so lane data lines up with edges
    sfr_pin_sync #(.W(`SFR_PIN_W), .INIT(`SFR_PIN_IDLE)) u_sync
    (
        .clock(clock),
        .reset_n(reset_n),
        .pin({cs_n_pin, serial_clock_pin, io_in}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    sfr_fifo #(.WIDTH(`SFR_BYTE_W), .DEPTH(`SFR_FIFO_DEPTH)) u_fifo
    (
        .clock(clock),
        .reset_n(reset_n),
        .clear(fifo_clear),
        .in_valid(array_valid && fetch_r),
        .in_ready(fifo_in_ready),
        .in_data(array_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    assign io_s = pin_lvl[7:0];
    assign cs_rise_e = pin_rise[9];
    assign cs_fall_e = pin_fall[9];
    assign sck_rise_e = pin_rise[8];
    assign sck_fall_e = pin_fall[8];
    assign wide_address_enable = bank_r[`SFR_BANK_WIDE_BIT];
    // a full fifo stalls prefetch until the serial side drains it
    assign array_rd = fetch_r && fifo_in_ready && array_valid;

    // command sequencer: all next values for the serial side
    always_comb
    begin
        state_nxt = state_r;
        cls_nxt = cls_r;
        wide_nxt = wide_r;
        xip_nxt = xip_r;
        fetch_nxt = fetch_r;
        dlp_act_nxt = dlp_act_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rd_addr_nxt = rd_addr_r;
        fetch_addr_nxt = fetch_addr_r;
        mode_nxt = mode_r;
        byte_nxt = byte_r;
        io_out_nxt = io_out_r;
        io_oe_nxt = io_oe_r;
        dcnt_nxt = dcnt_r;
        dlp_idx_nxt = dlp_idx_r;
        bit_nxt = bit_r;
        fifo_clear = 1'b0;
        fifo_pop = 1'b0;
        launch = 1'b0;
        start_lat = 1'b0;
        bank_nxt = bank_load ? bank_load_value : bank_r;
        ddr = (cls_r == CL_QDDR);
        quad_addr = (cls_r == CL_QIO) || ddr;
        sh_shift = quad_addr ? {sh_r[27:0], io_s[3:0]} : {sh_r[30:0], io_s[0]};
        op_full = {sh_r[6:0], io_s[0]};
        op_cls = op_decode(op_full);
        first_cnt = (state_r == ST_MODE) ? `SFR_MODE_EDGES : addr_edges(cls_r, wide_r);
        // double-rate capture starts on a rising edge, then takes both
        cap_edge = sck_rise_e || (ddr && sck_fall_e && cnt_r != first_cnt);
        out_edge = sck_fall_e || (ddr && sck_rise_e);
        lat_src = (state_r == ST_ADDR) ? sh_shift : sh_r;
        lat_addr = wide_r ? lat_src : {1'b0, bank_r[6:0], lat_src[23:0]};
        ndum = dummy_count(cls_r, config_register_one[`SFR_CR1_LC_LSB +: 2]);
        idx = 2'h3 - bit_r;
        cur = (bit_r == 2'h0) ? fifo_out_data : byte_r;
        if (array_rd)
            fetch_addr_nxt = fetch_addr_r + 32'h1;

        if (cs_rise_e)
        begin
            // select high ends any read at once; only a clean A nibble keeps xip
            state_nxt = ST_IDLE;
            io_oe_nxt = `SFR_OE_NONE;
            fetch_nxt = 1'b0;
            fifo_clear = 1'b1;
            xip_nxt = quad_addr && (state_r == ST_DUMMY || state_r == ST_DATA)
                && (mode_r[7:4] == `SFR_XIP_NIBBLE);
        end
        else if (cs_fall_e)
        begin
            sh_nxt = 32'h0;
            if (xip_r)
            begin
                state_nxt = ST_ADDR;
                cnt_nxt = addr_edges(cls_r, wide_r);
            end
            else
            begin
                state_nxt = ST_OPC;
                cnt_nxt = `SFR_OPCODE_EDGES;
            end
        end
        else if (sck_rise_e || sck_fall_e)
        begin
            unique case (state_r)
                ST_IDLE, ST_IGNORE:
                begin
                    state_nxt = state_r;
                end
                ST_OPC:
                begin
                    if (sck_rise_e)
                    begin
                        sh_nxt = {sh_r[30:0], io_s[0]};
                        cnt_nxt = cnt_r - 6'h1;
                        if (cnt_r == 6'h1)
                        begin
                            sh_nxt = 32'h0;
                            wide_nxt = op_is_wide(op_full) || wide_address_enable;
                            cls_nxt = op_cls;
                            cnt_nxt = addr_edges(op_cls, wide_nxt);
                            state_nxt = ST_ADDR;
                            if (op_cls == CL_NONE)
                                state_nxt = ST_IGNORE;
                            else if (op_cls >= CL_QOUT && !config_register_one[`SFR_CR1_QUAD_BIT])
                                state_nxt = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (cap_edge)
                    begin
                        sh_nxt = sh_shift;
                        cnt_nxt = cnt_r - 6'h1;
                        if (cnt_r == 6'h1 && quad_addr)
                        begin
                            state_nxt = ST_MODE;
                            cnt_nxt = `SFR_MODE_EDGES;
                        end
                        else if (cnt_r == 6'h1)
                            start_lat = 1'b1;
                    end
                end
                ST_MODE:
                begin
                    if (cap_edge)
                    begin
                        mode_nxt = {mode_r[3:0], io_s[3:0]};
                        cnt_nxt = cnt_r - 6'h1;
                        if (cnt_r == 6'h1)
                            start_lat = 1'b1;
                    end
                end
                ST_DUMMY:
                begin
                    // lanes are never sampled here
                    if (sck_fall_e && dcnt_r == 4'h0)
                        launch = 1'b1;
                    else
                    begin
                        if (sck_fall_e)
                            dcnt_nxt = dcnt_r - 4'h1;
                        if (ddr && learning_pattern_on
                            && ((sck_fall_e && dcnt_r == `SFR_DLP_START) || dlp_act_r))
                        begin
                            io_out_nxt = {8{learning_pattern[dlp_idx_r]}};
                            io_oe_nxt = `SFR_OE_QUAD;
                            dlp_idx_nxt = dlp_idx_r - 3'h1;
                            dlp_act_nxt = 1'b1;
                        end
                    end
                end
                ST_DATA:
                begin
                    launch = out_edge;
                end
                default:
                begin
                    state_nxt = ST_IGNORE;
                end
            endcase
        end

        // address is complete: start prefetch and the latency count
        if (start_lat)
        begin
            rd_addr_nxt = lat_addr;
            fetch_addr_nxt = lat_addr;
            fetch_nxt = 1'b1;
            fifo_clear = 1'b1;
            state_nxt = ST_DUMMY;
            io_oe_nxt = `SFR_OE_NONE;
            dlp_idx_nxt = `SFR_DLP_FIRST;
            dlp_act_nxt = 1'b0;
            bit_nxt = 2'h0;
            // double-rate input ends on a falling edge, which already opens a cycle
            dcnt_nxt = (ddr && ndum != 4'h0) ? ndum - 4'h1 : ndum;
        end

        // launch the next lane value; a fresh byte bumps the address
        if (launch)
        begin
            state_nxt = ST_DATA;
            dlp_act_nxt = 1'b0;
            if (bit_r == 2'h0)
            begin
                byte_nxt = fifo_out_data;
                fifo_pop = fifo_out_valid;
                rd_addr_nxt = rd_addr_r + 32'h1;
            end
            if (cls_r == CL_READ || cls_r == CL_FAST)
            begin
                io_out_nxt = 8'h00;
                io_out_nxt[1] = cur[{1'b0, idx}];
                io_out_nxt[5] = cur[{1'b1, idx}];
                io_oe_nxt = `SFR_OE_SINGLE;
                bit_nxt = bit_r + 2'h1;
            end
            else
            begin
                io_out_nxt = cur;
                io_oe_nxt = `SFR_OE_QUAD;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            cls_r <= CL_NONE;
            wide_r <= 1'b0;
            xip_r <= 1'b0;
            fetch_r <= 1'b0;
            dlp_act_r <= 1'b0;
            cnt_r <= 6'h00;
            sh_r <= 32'h0;
            rd_addr_r <= 32'h0;
            fetch_addr_r <= 32'h0;
            mode_r <= 8'h00;
            byte_r <= 8'h00;
            io_out_r <= 8'h00;
            io_oe_r <= `SFR_OE_NONE;
            bank_r <= `SFR_BANK_RESET;
            dcnt_r <= 4'h0;
            dlp_idx_r <= `SFR_DLP_FIRST;
            bit_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cls_r <= cls_nxt;
            wide_r <= wide_nxt;
            xip_r <= xip_nxt;
            fetch_r <= fetch_nxt;
            dlp_act_r <= dlp_act_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rd_addr_r <= rd_addr_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            mode_r <= mode_nxt;
            byte_r <= byte_nxt;
            io_out_r <= io_out_nxt;
            io_oe_r <= io_oe_nxt;
            bank_r <= bank_nxt;
            dcnt_r <= dcnt_nxt;
            dlp_idx_r <= dlp_idx_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign io_out = io_out_r;
    assign io_oe = io_oe_r;
    assign bank_value = bank_r;
    assign array_addr = fetch_addr_r;
    assign read_addr = rd_addr_r;
    assign enhanced_mode = xip_r;
    assign read_active = (state_r != ST_IDLE);

endmodule : sfr_array_read

// file: testbench/sfr_ar_asserts.sv
/* port checker for the array read block
   assumes config changes only while no command runs */
`timescale 1ns/1ps
module sfr_ar_asserts
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cs_n_pin,
    input wire logic serial_clock_pin,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe,
    input wire logic [7:0] config_register_one,
    input wire logic bank_load,
    input wire logic [7:0] bank_load_value,
    input wire logic [7:0] bank_value,
    input wire logic [31:0] array_addr,
    input wire logic array_rd,
    input wire logic read_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // pin sync delay plus one register before lanes go quiet
    a_sel_quiet: assert property ($rose(cs_n_pin) |-> ##[1:8] io_oe == 8'h00)
        else $error("lanes on after select high");
    a_sel_starts: assert property ($fell(cs_n_pin) |-> ##[3:8] read_active)
        else $error("no command after select low");
    a_lane_sets: assert property (io_oe inside {8'h00, 8'h22, 8'hFF})
        else $error("odd lane enables");
    // single-lane data holds through a rise; only the next fall may launch a bit
    a_out_fall: assert property ($rose(serial_clock_pin) && io_oe == 8'h22 |=>
        $stable(io_out) [*8]) else $error("output moved after a rise");
    a_bank_take: assert property (bank_load |=> bank_value == $past(bank_load_value))
        else $error("bank load lost");
    a_addr_step: assert property (array_rd |=>
        array_addr == $past(array_addr) + 32'h1) else $error("address did not step");
    a_idle_quiet: assert property (!read_active [*2] |-> io_oe == 8'h00)
        else $error("lanes on while idle");
    a_quad_gate: assert property (!config_register_one[1] |-> io_oe != 8'hFF)
        else $error("quad lanes without enable");
endmodule : sfr_ar_asserts

bind sfr_array_read sfr_ar_asserts chk (.*);

// file: testbench/sfr_host_model.sv
/* host controller model: select, serial clock and lanes
   assumes the bench calls one task at a time */
`timescale 1ns/1ps
module sfr_host_model
(
    output logic cs_n,
    output logic sck,
    output logic [7:0] io,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe
);
    logic [7:0] seen_oe, q, q2;
    // serial clock stands low outside frames
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        io = 8'h00;
        seen_oe = 8'h00;
    end
    // a new frame clears the record of driven lanes
    task sel(input logic v);
        #30 cs_n = v;
        if (!v)
            seen_oe = 8'h00;
    endtask : sel
    // lanes set while low, outputs sampled on the rise
    task cyc(input logic [7:0] v);
        io = v;
        #62.5 sck = 1'b1; // 8 MHz link stays below the contention limit
        q = io_out;
        seen_oe = seen_oe | io_oe;
        #62.5 sck = 1'b0;
    endtask : cyc
    // msb first, a bit on lane 0 or a nibble on lanes 3..0
    task send(input logic [31:0] v, input int n, input int nib);
        for (int i = n - 1; i >= 0; i--)
            cyc(nib ? {4'h0, v[4 * i +: 4]} : {7'h00, v[i]});
    endtask : send
    // double-rate cycle: lanes move mid-phase so no edge races them
    task dcyc(input logic [7:0] a, b);
        #31.25 io = a;
        #31.25 sck = 1'b1;
        q = io_out;
        seen_oe = seen_oe | io_oe;
        #31.25 io = b;
        #31.25 q2 = io_out;
        sck = 1'b0;
    endtask : dcyc
    // double-rate nibbles, high first, one on each edge
    task dsend(input logic [31:0] v, input int n);
        for (int i = n - 1; i > 0; i -= 2)
            dcyc({4'h0, v[4 * i +: 4]}, {4'h0, v[4 * i - 4 +: 4]});
    endtask : dsend
    // released lanes toggle so stale drive never looks valid
    task idle(input int n);
        repeat (n) cyc(~io);
    endtask : idle
    // a byte in four cycles on lanes 1 and 5, or one on all
    task get(input int quad, output logic [7:0] b);
        for (int i = 0; i < (quad ? 1 : 4); i++)
        begin
            cyc(~io);
            b = quad ? q : {b[6:4], q[5], b[2:0], q[1]};
        end
    endtask : get
endmodule : sfr_host_model

// file: testbench/tb_sfr_array_read.sv
/* self-checking bench for the array read block
   assumes the host model and checker are compiled first */
`timescale 1ns/1ps
module tb_sfr_array_read;
    logic clock, reset_n, cs_n_pin, serial_clock_pin, learning_pattern_on, bank_load;
    logic array_rd, array_valid, enhanced_mode, read_active;
    logic [7:0] io_in, io_out, io_oe, config_register_one, learning_pattern;
    logic [7:0] bank_load_value, bank_value, array_rdata, got;
    logic [31:0] array_addr, read_addr;
    int num_errors, num_checks;
    // 125 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // data mixes top and bottom address bytes so bank bits show
    function automatic logic [7:0] byte_at(input logic [31:0] a);
        return a[7:0] ^ a[31:24] ^ 8'hA5;
    endfunction : byte_at
    assign array_rdata = byte_at(array_addr);
    sfr_host_model host
    (
        .cs_n(cs_n_pin),
        .sck(serial_clock_pin),
        .io(io_in),
        .io_out(io_out),
        .io_oe(io_oe)
    );
    sfr_array_read uut (.*);
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task results;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task bank(input logic [7:0] v);
        @(negedge clock);
        bank_load_value = v;
        bank_load = 1'b1;
        @(negedge clock);
        bank_load = 1'b0;
        check("bank", bank_value, v);
    endtask : bank
    // one read; opcode 00 means none is sent
    task rd(input logic [7:0] op, input logic [31:0] a, ea, input logic [7:0] eo,
            input int an, nib, dum, quad, n);
        host.sel(1'b0);
        if (op !== 8'h00)
            host.send({24'h0, op}, 8, 0);
        host.send(a, an, nib);
        host.idle(dum);
        for (int i = 0; i < n; i++)
        begin
            host.get(quad, got);
            check("data", got, byte_at(ea + i));
        end
        check("lanes", host.seen_oe, eo);
        host.sel(1'b1);
        repeat (10) @(negedge clock);
        check("idle lanes", io_oe, 8'h00);
        check("active", read_active, 1'b0);
    endtask : rd
    // reset, then each read command in turn except opcodes EC and EE
    initial
    begin
        num_errors = 0;
        num_checks = 0;
        reset_n = 1'b0;
        bank_load = 1'b0;
        bank_load_value = 8'h00;
        config_register_one = 8'hC0;
        learning_pattern_on = 1'b0;
        learning_pattern = 8'h5A;
        array_valid = 1'b1;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        repeat (5) @(negedge clock);
        check("bank reset", bank_value, 8'h00);
        bank(8'h05);
        rd(8'h03, 32'h00123456, 32'h05123456, 8'h22, 24, 0, 0, 0, 2);
        rd(8'h13, 32'hFFFFFFFF, 32'hFFFFFFFF, 8'h22, 32, 0, 0, 0, 2);
        bank(8'h85);
        rd(8'h03, 32'h3A0000FF, 32'h3A0000FF, 8'h22, 32, 0, 0, 0, 2);
        @(negedge clock) config_register_one = 8'h00;
        rd(8'h0B, 32'h11223344, 32'h11223344, 8'h22, 32, 0, 8, 0, 1);
        rd(8'h6B, 32'h00000000, 32'h00000000, 8'h00, 32, 0, 8, 1, 0);
        @(negedge clock) config_register_one = 8'h02;
        rd(8'h6B, 32'h44556677, 32'h44556677, 8'hFF, 32, 0, 8, 1, 3);
        @(negedge clock) config_register_one = 8'hC2;
        rd(8'h0C, 32'h01020304, 32'h01020304, 8'h22, 32, 0, 0, 0, 1);
        rd(8'h6C, 32'h55AA55AA, 32'h55AA55AA, 8'hFF, 32, 0, 0, 1, 2);
        bank(8'h05);
        rd(8'hEB, 32'h00ABCDA0, 32'h0500ABCD, 8'hFF, 8, 1, 1, 1, 2);
        check("xip armed", enhanced_mode, 1'b1);
        rd(8'h00, 32'h0000F000, 32'h050000F0, 8'hFF, 8, 1, 1, 1, 2);
        check("xip released", enhanced_mode, 1'b0);
        // double-rate quad read with the learning pattern ahead of data
        @(negedge clock) learning_pattern_on = 1'b1; // code 3 gives seven
        host.sel(1'b0);
        host.send(32'h000000ED, 8, 0);
        host.dsend(32'h12345600, 8);
        repeat (3) host.dcyc(8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            host.dcyc(8'h00, 8'h00);
            got = {got[5:0], host.q[0], host.q2[0]};
        end
        check("pattern", got, learning_pattern);
        for (int i = 0; i < 4; i += 2)
        begin
            host.dcyc(8'h00, 8'h00);
            check("ddr rise", host.q, byte_at(32'h05123456 + i));
            check("ddr fall", host.q2, byte_at(32'h05123457 + i));
        end
        check("ddr lanes", host.seen_oe, 8'hFF);
        host.sel(1'b1);
        repeat (10) @(negedge clock);
        check("ddr idle", io_oe, 8'h00);
        results();
    end
endmodule : tb_sfr_array_read
